// ### verilog/blc_pkg.sv
`default_nettype none
package blc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 125;
  localparam int FILT_STEP_NS = 10000;
  localparam int FILT_TICK_CYC = (FILT_STEP_NS * CLK_MHZ) / 1000;
  localparam int SPEED_WIN_US = 1000;
  localparam int SPEED_WIN_CYC_DFLT = SPEED_WIN_US * CLK_MHZ;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_AMOUNT = 8'h04;
  localparam logic [7:0] OFS_FILT_TC = 8'h08;
  localparam logic [7:0] OFS_GEAR = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COMP = 8'h14;
  localparam logic [7:0] OFS_TARGET = 8'h18;
  localparam logic [7:0] OFS_MON_SEL = 8'h1C;
  localparam logic [7:0] OFS_OPT1_SEL = 8'h20;
  localparam logic [7:0] OFS_OPT2_SEL = 8'h24;
  localparam logic [7:0] OFS_FB_REF = 8'h28;
  localparam logic [7:0] OFS_MON0 = 8'h30;
  localparam logic [7:0] OFS_MON3 = 8'h3C;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int CTRL_DIR_BIT = 0;
  localparam int ST_ACTIVE_BIT = 0;
  localparam int ST_DIR_BIT = 1;
  localparam int ST_LATCH_BIT = 2;
  localparam int MON_SLOTS = 4;
  localparam logic signed [31:0] AMOUNT_RST = 32'sh0;
  localparam logic signed [31:0] AMOUNT_MAX = 32'sd500000;
  localparam logic [15:0] FILT_TC_RST = 16'h0000;
  localparam logic [15:0] GEAR_RST = 16'h0001;
  localparam logic [15:0] MON_SEL_RST = 16'h0000;
  localparam logic [15:0] OPT_SEL_RST = 16'h0000;

  // ****************************************
  // monitor slot codes
  // ****************************************
  localparam logic [3:0] MC_FILT_REF = 4'h0;
  localparam logic [3:0] MC_REF_POS = 4'h1;
  localparam logic [3:0] MC_POS_ERR = 4'h2;
  localparam logic [3:0] MC_MACH_FB = 4'h3;
  localparam logic [3:0] MC_LATCH_FB = 4'h4;
  localparam logic [3:0] MC_UNFILT_REF = 4'h5;
  localparam logic [3:0] MC_TARGET = 4'h6;
  localparam logic [3:0] MC_OPT_ONE = 4'hE;
  localparam logic [3:0] MC_OPT_TWO = 4'hF;

  // ****************************************
  // option monitor select codes
  // ****************************************
  localparam logic [15:0] OC_ERR_LO = 16'h0003;
  localparam logic [15:0] OC_ERR_HI = 16'h0004;
  localparam logic [15:0] OC_ENC_LO = 16'h000A;
  localparam logic [15:0] OC_ENC_HI = 16'h000B;
  localparam logic [15:0] OC_SPEED = 16'h0017;
  localparam logic [15:0] OC_ERR_MON = 16'h0018;
  localparam logic [15:0] OC_REF_CNT = 16'h001C;
  localparam logic [15:0] OC_FB_CNT = 16'h001D;
  localparam logic [15:0] OC_PREV_LATCH = 16'h0080;

  typedef enum logic {
    DIR_FWD = 1'b0,
    DIR_REV = 1'b1
  } blc_dir_t;

endpackage
`default_nettype wire

// ### verilog/blc_backlash_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - divided pulse output counts every driven pulse, compensation included
// - servo on, moving in compensation direction: compensation added to reference
// - moving opposite to compensation direction: no compensation added
// - machine feedback equals shaft position minus applied compensation
// - servo off: no compensation, reference position follows feedback
// - overtravel from limit signal or software limit: no compensation, reference position keeps counting increments
// - compensation only in position control, dropped when leaving it
// - entering position control applies compensation as with servo on
// - reference speed monitor uses reference before compensation
// - position error measured against compensated reference
// - reference counter accumulates reference before compensation
// - feedback counter shows driven encoder count, pulses and reference units
// - slot codes 0 to 6 pick positions, codes E and F option monitors
// - machine and latched feedback monitors have compensation subtracted
// - each option monitor follows its own select setting
// - option codes give position error as lower and upper 32-bit halves
// - option codes give encoder count halves; next two codes reserved
// - option codes mirror speed, error, reference counter, feedback counter
// - option code gives previous latched feedback in pulses, compensation removed
// - direction select: 0 forward references, 1 reverse references
// - amount is signed tenths of reference unit, rounded to whole pulses
// - compensation passes a first-order lag; time constant zero bypasses
module blc_backlash_monitor
  import blc_pkg::*;
#(
  parameter int SPEED_WIN_CYC = SPEED_WIN_CYC_DFLT
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // drive state
  input wire logic servo_on,
  input wire logic overtravel,
  input wire logic position_mode,
  // position reference, reference units
  input wire logic signed [31:0] ref_inc,
  input wire logic ref_inc_valid,
  // encoder shaft position, pulses
  input wire logic signed [31:0] shaft_pos,
  // latch pin
  input wire logic latch_pin,
  // outputs
  output logic signed [31:0] motor_cmd_pos,
  output logic [31:0] divided_pulse_count,
  output logic comp_active
);

  // ****************************************
  // settings
  // ****************************************
  blc_dir_t backlash_direction_select_q;
  logic signed [31:0] backlash_amount_setting_q;
  logic [15:0] backlash_filter_time_constant_q;
  logic [15:0] filt_tc_eff_q;
  logic [15:0] gear_q;
  logic signed [31:0] target_position_q;
  logic [15:0] mon_sel_q;
  logic [15:0] option_monitor_one_select_q;
  logic [15:0] option_monitor_two_select_q;
  function automatic logic signed [31:0] clamp_amount(input logic signed [31:0] a);
    if (a > AMOUNT_MAX) begin
      return AMOUNT_MAX;
    end else if (a < -AMOUNT_MAX) begin
      return -AMOUNT_MAX;
    end
    return a;
  endfunction

  always_ff @(posedge clock) begin
    if (rst) begin
      backlash_direction_select_q <= DIR_FWD;
      backlash_amount_setting_q <= AMOUNT_RST;
      backlash_filter_time_constant_q <= FILT_TC_RST;
      gear_q <= GEAR_RST;
      target_position_q <= 32'sh0;
      mon_sel_q <= MON_SEL_RST;
      option_monitor_one_select_q <= OPT_SEL_RST;
      option_monitor_two_select_q <= OPT_SEL_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: backlash_direction_select_q <= blc_dir_t'(reg_wdata[CTRL_DIR_BIT]);
        OFS_AMOUNT: backlash_amount_setting_q <= clamp_amount($signed(reg_wdata));
        OFS_FILT_TC: backlash_filter_time_constant_q <= reg_wdata[15:0];
        OFS_GEAR: gear_q <= reg_wdata[15:0];
        OFS_TARGET: target_position_q <= $signed(reg_wdata);
        OFS_MON_SEL: mon_sel_q <= reg_wdata[15:0];
        OFS_OPT1_SEL: option_monitor_one_select_q <= reg_wdata[15:0];
        OFS_OPT2_SEL: option_monitor_two_select_q <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // zero gear would divide by zero; treat as one
  logic signed [16:0] gear_s;
  assign gear_s = (gear_q == 16'h0000) ? 17'sh1 : $signed({1'b0, gear_q});

  // ****************************************
  // direction and enable
  // ****************************************
  blc_dir_t last_dir_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      last_dir_q <= DIR_FWD;
    end else if (ref_inc_valid && ref_inc != 32'sh0) begin
      last_dir_q <= ref_inc[31] ? DIR_REV : DIR_FWD;
    end
  end

  logic drive_ok;
  logic comp_allowed;
  assign drive_ok = servo_on && !overtravel && position_mode;
  assign comp_allowed = drive_ok && (last_dir_q == backlash_direction_select_q);

  // ****************************************
  // compensation amount in pulses
  // ****************************************
  // rounds half away from zero
  function automatic logic signed [31:0] to_pulses(
    input logic signed [31:0] a,
    input logic signed [16:0] g
  );
    logic signed [63:0] p;
    logic [63:0] m;
    p = 64'(a) * 64'(g);
    m = p[63] ? 64'(-p) : 64'(p);
    m = (m + 64'h5) / 64'hA;
    return p[63] ? -$signed(m[31:0]) : $signed(m[31:0]);
  endfunction

  logic signed [31:0] amount_pulses;
  logic signed [31:0] comp_target;
  assign amount_pulses = to_pulses(backlash_amount_setting_q, gear_s);
  assign comp_target = comp_allowed ? amount_pulses : 32'sh0;

  // ****************************************
  // lag filter
  // ****************************************
  logic [10:0] tick_cnt_q;
  logic tick;
  assign tick = (tick_cnt_q == 11'(FILT_TICK_CYC - 1));
  always_ff @(posedge clock) begin
    if (rst || tick) begin
      tick_cnt_q <= 11'h000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 11'h001;
    end
  end

  // a new time constant only takes effect at standstill
  logic signed [31:0] shaft_prev_q;
  logic standstill;
  assign standstill = !(ref_inc_valid && ref_inc != 32'sh0) && (shaft_pos == shaft_prev_q);
  always_ff @(posedge clock) begin
    if (rst) begin
      shaft_prev_q <= 32'sh0;
      filt_tc_eff_q <= FILT_TC_RST;
    end else begin
      shaft_prev_q <= shaft_pos;
      if (standstill) begin
        filt_tc_eff_q <= backlash_filter_time_constant_q;
      end
    end
  end

  logic signed [31:0] comp_q;
  logic signed [32:0] comp_diff;
  logic signed [32:0] comp_step;
  always_comb begin
    comp_diff = 33'(comp_target) - 33'(comp_q);
    comp_step = comp_diff / 33'($signed({1'b0, filt_tc_eff_q}));
    // integer step would stall short of the target
    if (comp_step == 33'sh0 && comp_diff != 33'sh0) begin
      comp_step = comp_diff[32] ? -33'sh1 : 33'sh1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      comp_q <= 32'sh0;
    end else if (!drive_ok) begin
      comp_q <= 32'sh0;
    end else if (filt_tc_eff_q == 16'h0000) begin
      comp_q <= comp_target;
    end else if (tick) begin
      comp_q <= 32'(33'(comp_q) + comp_step);
    end
  end

  // ****************************************
  // positions
  // ****************************************
  logic signed [31:0] mach_fb_pulses;
  logic signed [31:0] mach_fb_ref;
  assign mach_fb_pulses = shaft_pos - comp_q;
  assign mach_fb_ref = 32'(33'(mach_fb_pulses) / 33'(gear_s));

  logic signed [31:0] ref_pos_q;
  logic signed [31:0] mach_fb_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      ref_pos_q <= 32'sh0;
      mach_fb_q <= 32'sh0;
    end else begin
      mach_fb_q <= mach_fb_ref;
      if (!servo_on) begin
        ref_pos_q <= mach_fb_ref;
      end else if (ref_inc_valid) begin
        ref_pos_q <= ref_pos_q + ref_inc;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      motor_cmd_pos <= 32'sh0;
      divided_pulse_count <= 32'h0;
      comp_active <= 1'b0;
    end else begin
      motor_cmd_pos <= 32'(64'(ref_pos_q) * 64'(gear_s)) + comp_q;
      divided_pulse_count <= shaft_pos;
      comp_active <= (comp_q != 32'sh0);
    end
  end

  logic signed [63:0] pos_err_q;
  always_ff @(posedge clock) begin
    if (rst) begin
      pos_err_q <= 64'sh0;
    end else begin
      pos_err_q <= (64'(motor_cmd_pos) - 64'(shaft_pos)) / 64'(gear_s);
    end
  end

  // ****************************************
  // reference counters
  // ****************************************
  logic signed [31:0] ref_cnt_q;
  logic signed [31:0] speed_acc_q;
  logic signed [31:0] speed_mon_q;
  logic [31:0] win_cnt_q;
  logic signed [31:0] inc_now;
  assign inc_now = ref_inc_valid ? ref_inc : 32'sh0;

  always_ff @(posedge clock) begin
    if (rst) begin
      ref_cnt_q <= 32'sh0;
    end else begin
      ref_cnt_q <= ref_cnt_q + inc_now;
    end
  end

  // speed in reference units per window
  always_ff @(posedge clock) begin
    if (rst) begin
      win_cnt_q <= 32'h0;
      speed_acc_q <= 32'sh0;
      speed_mon_q <= 32'sh0;
    end else if (win_cnt_q == 32'(SPEED_WIN_CYC - 1)) begin
      win_cnt_q <= 32'h0;
      speed_acc_q <= 32'sh0;
      speed_mon_q <= speed_acc_q + inc_now;
    end else begin
      win_cnt_q <= win_cnt_q + 32'h1;
      speed_acc_q <= speed_acc_q + inc_now;
    end
  end

  logic signed [31:0] fb_ref_cnt;
  assign fb_ref_cnt = 32'(33'(shaft_pos) / 33'(gear_s));

  // ****************************************
  // latch
  // ****************************************
  logic lat_s1_q;
  logic lat_s2_q;
  logic lat_s3_q;
  logic lat_valid_q;
  logic signed [31:0] lat_ref_q;
  logic signed [31:0] lat_pls_q;
  logic signed [31:0] lat_prev_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      lat_s1_q <= 1'b0;
      lat_s2_q <= 1'b0;
      lat_s3_q <= 1'b0;
    end else begin
      lat_s1_q <= latch_pin;
      lat_s2_q <= lat_s1_q;
      lat_s3_q <= lat_s2_q;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      lat_valid_q <= 1'b0;
      lat_ref_q <= 32'sh0;
      lat_pls_q <= 32'sh0;
      lat_prev_q <= 32'sh0;
    end else if (lat_s2_q && !lat_s3_q) begin
      lat_valid_q <= 1'b1;
      lat_ref_q <= mach_fb_ref;
      lat_pls_q <= mach_fb_pulses;
      lat_prev_q <= lat_pls_q;
    end
  end

  // ****************************************
  // monitor selection
  // ****************************************
  function automatic logic [31:0] opt_value(input logic [15:0] sel);
    case (sel)
      OC_ERR_LO: return pos_err_q[31:0];
      OC_ERR_HI: return pos_err_q[63:32];
      OC_ENC_LO: return shaft_pos;
      OC_ENC_HI: return {32{shaft_pos[31]}};
      OC_SPEED: return speed_mon_q;
      OC_ERR_MON: return pos_err_q[31:0];
      OC_REF_CNT: return ref_cnt_q;
      OC_FB_CNT: return shaft_pos;
      OC_PREV_LATCH: return lat_prev_q;
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic [31:0] slot_value(input logic [3:0] code);
    case (code)
      MC_FILT_REF: return ref_pos_q;
      MC_REF_POS: return ref_pos_q;
      MC_POS_ERR: return pos_err_q[31:0];
      MC_MACH_FB: return mach_fb_q;
      MC_LATCH_FB: return lat_ref_q;
      MC_UNFILT_REF: return ref_pos_q;
      MC_TARGET: return target_position_q;
      MC_OPT_ONE: return opt_value(option_monitor_one_select_q);
      MC_OPT_TWO: return opt_value(option_monitor_two_select_q);
      default: return 32'h0;
    endcase
  endfunction

  logic [31:0] mon_q [MON_SLOTS];
  for (genvar gi = 0; gi < MON_SLOTS; gi++) begin : g_slot
    always_ff @(posedge clock) begin
      if (rst) begin
        mon_q[gi] <= 32'h0;
      end else begin
        mon_q[gi] <= slot_value(mon_sel_q[4*gi +: 4]);
      end
    end
  end

  // ****************************************
  // register read
  // ****************************************
  always_ff @(posedge clock) begin
    if (rst || !reg_rd) begin
      reg_rdata <= 32'h0;
    end else begin
      case (reg_addr)
        OFS_CTRL: reg_rdata <= {31'h0, backlash_direction_select_q};
        OFS_AMOUNT: reg_rdata <= backlash_amount_setting_q;
        OFS_FILT_TC: reg_rdata <= {16'h0, backlash_filter_time_constant_q};
        OFS_GEAR: reg_rdata <= {16'h0, gear_q};
        OFS_STATUS: begin
          reg_rdata <= 32'h0;
          reg_rdata[ST_ACTIVE_BIT] <= comp_allowed;
          reg_rdata[ST_DIR_BIT] <= last_dir_q;
          reg_rdata[ST_LATCH_BIT] <= lat_valid_q;
        end
        OFS_COMP: reg_rdata <= comp_q;
        OFS_FB_REF: reg_rdata <= fb_ref_cnt;
        OFS_TARGET: reg_rdata <= target_position_q;
        OFS_MON_SEL: reg_rdata <= {16'h0, mon_sel_q};
        OFS_OPT1_SEL: reg_rdata <= {16'h0, option_monitor_one_select_q};
        OFS_OPT2_SEL: reg_rdata <= {16'h0, option_monitor_two_select_q};
        default: begin
          if (reg_addr >= OFS_MON0 && reg_addr <= OFS_MON3 && reg_addr[1:0] == 2'h0) begin
            reg_rdata <= mon_q[reg_addr[3:2]];
          end else begin
            reg_rdata <= 32'h0;
          end
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// ### testbench/blc_props.sv
`timescale 1ns/1ps
`default_nettype none
module blc_props (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // drive state and datapath
  input wire logic servo_on,
  input wire logic overtravel,
  input wire logic position_mode,
  input wire logic ref_inc_valid,
  input wire logic signed [31:0] shaft_pos,
  input wire logic signed [31:0] motor_cmd_pos,
  input wire logic [31:0] divided_pulse_count,
  input wire logic comp_active
);
  // *****
  // assertions
  // *****
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_divided_copy: assert property (!$past(rst) && !$past(rst, 2)
    |-> divided_pulse_count == $past(shaft_pos))
    else $error("divided count does not follow shaft");
  a_servo_off_none: assert property (!servo_on [*2] |=> !comp_active)
    else $error("compensation with servo off");
  a_overtravel_none: assert property (overtravel [*2] |=> !comp_active)
    else $error("compensation during overtravel");
  a_mode_off_none: assert property (!position_mode [*2] |=> !comp_active)
    else $error("compensation outside position control");
  a_comp_cause: assert property ($rose(comp_active) |-> $past(servo_on, 2)
    && !$past(overtravel, 2) && $past(position_mode, 2))
    else $error("compensation rose without its conditions");
  // no increment, no register write and no compensation: the command must stand still
  a_cmd_steady: assert property (
    (servo_on && position_mode && !overtravel && !ref_inc_valid && !reg_wr && !comp_active) [*4]
    |-> $stable(motor_cmd_pos))
    else $error("command moved without cause");
  a_reset_quiet: assert property (disable iff (1'b0) rst
    |=> motor_cmd_pos == 32'sh0 && !comp_active && divided_pulse_count == 32'h0)
    else $error("outputs not cleared by reset");
endmodule
bind blc_backlash_monitor blc_props i_blc_props (
  .clock(clock),
  .rst(rst),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .servo_on(servo_on),
  .overtravel(overtravel),
  .position_mode(position_mode),
  .ref_inc_valid(ref_inc_valid),
  .shaft_pos(shaft_pos),
  .motor_cmd_pos(motor_cmd_pos),
  .divided_pulse_count(divided_pulse_count),
  .comp_active(comp_active)
);
`default_nettype wire

// ### testbench/blc_motor_plant.sv
`timescale 1ns/1ps
`default_nettype none
module blc_motor_plant (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // drive side
  input wire logic servo_on,
  input wire logic signed [31:0] motor_cmd_pos,
  // encoder
  output logic signed [31:0] shaft_pos
);
  // *****
  // motor and encoder
  // *****
  // shaft lags the command a cycle; unpowered it coasts where it stopped
  always_ff @(posedge clock) begin
    if (rst) begin
      shaft_pos <= 32'sh0;
    end else if (servo_on) begin
      shaft_pos <= motor_cmd_pos;
    end
  end
endmodule
`default_nettype wire

// ### testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
  import blc_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic servo_on = 1'b1;
  logic overtravel = 1'b0;
  logic position_mode = 1'b1;
  logic signed [31:0] ref_inc = 32'sh0;
  logic ref_inc_valid = 1'b0;
  logic signed [31:0] shaft_pos;
  logic latch_pin = 1'b0;
  logic signed [31:0] motor_cmd_pos;
  logic [31:0] divided_pulse_count;
  logic comp_active;
  int n_errors = 0;
  int compares = 0;
  // ref 3 units, gear 4, comp 4 pulses: shaft 16, feedback 3, error 0
  logic [31:0] slot_exp [7] = '{32'h3, 32'h3, 32'h0, 32'h3, 32'h3, 32'h3, 32'h55};
  logic [15:0] opt_code [11] = '{OC_ERR_LO, OC_ERR_HI, OC_ENC_LO, OC_ENC_HI, 16'h000C,
    16'h000D, OC_SPEED, OC_ERR_MON, OC_REF_CNT, OC_FB_CNT, OC_PREV_LATCH};
  logic [31:0] opt_exp [11] = '{32'h0, 32'h0, 32'h10, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h3, 32'h10, 32'hC};

  always #4 clock = ~clock;

  blc_backlash_monitor #(.SPEED_WIN_CYC(16)) i_blc_backlash_monitor (
    .clock(clock),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .servo_on(servo_on),
    .overtravel(overtravel),
    .position_mode(position_mode),
    .ref_inc(ref_inc),
    .ref_inc_valid(ref_inc_valid),
    .shaft_pos(shaft_pos),
    .latch_pin(latch_pin),
    .motor_cmd_pos(motor_cmd_pos),
    .divided_pulse_count(divided_pulse_count),
    .comp_active(comp_active)
  );

  blc_motor_plant i_blc_motor_plant (
    .clock(clock),
    .rst(rst),
    .servo_on(servo_on),
    .motor_cmd_pos(motor_cmd_pos),
    .shaft_pos(shaft_pos)
  );

  // *****
  // helpers
  // *****
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    idle(1);
    reg_wr <= 1'b0;
    idle(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    idle(1);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
    idle(1);
  endtask
  task automatic step(input logic signed [31:0] v);
    ref_inc <= v;
    ref_inc_valid <= 1'b1;
    idle(1);
    ref_inc_valid <= 1'b0;
    idle(8);
  endtask
  task automatic results;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // *****
  // scenarios
  // *****
  task automatic t_regs;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_AMOUNT, AMOUNT_RST);
    rd(OFS_FILT_TC, 32'(FILT_TC_RST));
    rd(OFS_GEAR, 32'(GEAR_RST));
    wr(OFS_COMP, 32'h5);
    rd(OFS_COMP, 32'h0);
    rd(8'h2C, 32'h0);
  endtask
  task automatic t_fwd;
    wr(OFS_AMOUNT, 32'hF);
    step(32'sh1);
    rd(OFS_COMP, 32'h2);
    wr(OFS_AMOUNT, 32'hFFFFFFF1);
    idle(4);
    rd(OFS_COMP, 32'hFFFFFFFE);
    wr(OFS_AMOUNT, 32'h000927C0);
    rd(OFS_AMOUNT, AMOUNT_MAX);
    idle(4);
    rd(OFS_COMP, 32'h0000C350);
    wr(OFS_GEAR, 32'h4);
    wr(OFS_AMOUNT, 32'hA);
    step(32'sh2);
    rd(OFS_COMP, 32'h4);
    #1;
    chk(32'(comp_active), 32'h1);
    chk(divided_pulse_count, 32'h10);
    chk(motor_cmd_pos, 32'h10);
    idle(1);
  endtask
  task automatic t_filter;
    wr(OFS_FILT_TC, 32'h1);
    wr(OFS_AMOUNT, 32'h14);
    idle(8);
    rd(OFS_COMP, 32'h4);
    idle(1300);
    rd(OFS_COMP, 32'h8);
    wr(OFS_FILT_TC, 32'h0);
    wr(OFS_AMOUNT, 32'hA);
    idle(8);
    rd(OFS_COMP, 32'h4);
  endtask
  task automatic t_slots;
    for (int i = 0; i < 2; i++) begin
      latch_pin <= 1'b1;
      idle(4);
      latch_pin <= 1'b0;
      idle(8);
    end
    rd(OFS_STATUS, 32'h5);
    wr(OFS_TARGET, 32'h55);
    for (int c = 0; c < 7; c++) begin
      wr(OFS_MON_SEL, 32'(c));
      idle(1);
      rd(OFS_MON0, slot_exp[c]);
    end
    wr(OFS_MON_SEL, 32'h6000);
    idle(1);
    rd(OFS_MON3, 32'h55);
  endtask
  task automatic t_opts;
    wr(OFS_MON_SEL, 32'hFE);
    wr(OFS_OPT2_SEL, 32'(OC_FB_CNT));
    for (int i = 0; i < 11; i++) begin
      wr(OFS_OPT1_SEL, 32'(opt_code[i]));
      idle(1);
      rd(OFS_MON0, opt_exp[i]);
    end
    rd(OFS_MON0 + 8'h04, 32'h10);
    rd(OFS_FB_REF, 32'h4);
  endtask
  task automatic t_rev;
    step(-32'sh1);
    rd(OFS_COMP, 32'h0);
    wr(OFS_MON_SEL, 32'h3);
    idle(1);
    rd(OFS_MON0, 32'h2);
    #1;
    chk(divided_pulse_count, 32'h8);
    idle(1);
    // a zero increment must not turn the held reverse direction round
    step(32'sh0);
    wr(OFS_CTRL, 32'h1);
    idle(4);
    rd(OFS_COMP, 32'h4);
    wr(OFS_CTRL, 32'h0);
    idle(4);
    rd(OFS_COMP, 32'h0);
    step(32'sh1);
    rd(OFS_COMP, 32'h4);
  endtask
  task automatic off_check;
    idle(4);
    rd(OFS_COMP, 32'h0);
    #1;
    chk(32'(comp_active), 32'h0);
    idle(1);
    overtravel <= 1'b0;
    position_mode <= 1'b1;
    servo_on <= 1'b1;
    idle(4);
    rd(OFS_COMP, 32'h4);
  endtask
  task automatic t_inhibit;
    overtravel <= 1'b1;
    off_check();
    position_mode <= 1'b0;
    off_check();
    servo_on <= 1'b0;
    off_check();
    // reference followed the shaft while unpowered: one unit further on
    wr(OFS_MON_SEL, 32'h1);
    idle(1);
    rd(OFS_MON0, 32'h4);
  endtask
  task automatic t_speed;
    wr(OFS_MON_SEL, 32'hFE);
    wr(OFS_OPT1_SEL, 32'(OC_SPEED));
    wr(OFS_OPT2_SEL, 32'(OC_ERR_LO));
    // one unit every cycle: each window sums 16, shaft trails by one unit
    ref_inc <= 32'sh1;
    ref_inc_valid <= 1'b1;
    idle(40);
    rd(OFS_MON0, 32'h10);
    rd(OFS_MON0 + 8'h04, 32'h1);
    ref_inc_valid <= 1'b0;
    idle(1);
  endtask

  // *****
  // sequence and watchdog
  // *****
  initial begin
    idle(8);
    rst <= 1'b0;
    idle(1);
    t_regs();
    t_fwd();
    t_filter();
    t_slots();
    t_opts();
    t_rev();
    t_inhibit();
    t_speed();
    results();
  end
  // whole run is near 1700 cycles; a hang is cut well beyond that
  initial begin
    idle(20000);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule
`default_nettype wire
